// [pmc_defs.vh]
// constants for the power mode control block
`ifndef PMC_DEFS_VH
`define PMC_DEFS_VH
`define PMC_REG_ADDR 8'h87
`define PMC_RESET_VALUE 8'h00
`define PMC_BIT_IDLE 0
`define PMC_BIT_STOP 1
`define PMC_FLAGS_LSB 2
`define PMC_FLAGS_MSB 6
`define PMC_BIT_BAUD 7
`define PMC_RESET_VECTOR 16'h0000
`define PMC_MCD_TIMEOUT_US 100
`define PMC_CLK_MHZ 25
`define PMC_MCD_CYCLES (`PMC_MCD_TIMEOUT_US * `PMC_CLK_MHZ)
`endif

// [pmc_power_mode.v]
// power mode control register with idle and stop sequencing
`timescale 1ns/1ps
//
// What this block does
// - setting the idle select bit halts the cpu once the setting instruction completes.
// - in idle all state is kept and peripheral, timer and interrupt clocks keep running.
// - an enabled interrupt clears idle and resumes the cpu, which then services it.
// - a reset that ends idle runs the normal reset sequence from address zero.
// - an enabled watchdog timeout reset ends idle so the core cannot idle forever.
// - setting the stop select bit halts cpu and oscillators once the instruction completes.
// - stop ends only through reset, restarting at address zero; interrupts do not wake it.
// - in stop only the missing clock detector runs, and its timeout resets the device.
// - the stop and idle select bits always read back as zero.
// - the baud doubler bit selects double serial baud rate when set.
// - the five general flag bits are plain read/write storage.
`include "pmc_defs.vh"

module pmc_power_mode #(
    parameter MCD_CYCLES = `PMC_MCD_CYCLES
) (
    input wire clk_in,
    input wire resetn_in,
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_write_in,
    input wire reg_read_in,
    input wire instr_done_in,
    input wire irq_enabled_in,
    input wire watchdog_timeout_in,
    input wire mcd_enable_in,
    input wire mcd_clock_seen_in,
    output reg [7:0] reg_rdata_out,
    output reg cpu_clk_en_out,
    output reg periph_clk_en_out,
    output reg osc_en_out,
    output reg idle_out,
    output reg stop_out,
    output reg baud_doubler_out,
    output reg [4:0] general_flags_out,
    output reg internal_reset_out,
    output reg [15:0] reset_vector_out
);

    // ************************************************************
    // states
    // ************************************************************
    // one-hot; a stop request shares the pending state with idle and is
    // told apart by stop_pending, so there is no separate stop-pending code
    localparam ST_RUN = 4'h1;
    localparam ST_IDLE_PEND = 4'h2;
    localparam ST_IDLE = 4'h4;
    localparam ST_STOP = 4'h8;

    reg [3:0] state;
    reg [3:0] next_state;
    reg stop_pending;
    reg next_stop_pending;
    reg baud_doubler;
    reg [4:0] general_flags;
    reg [31:0] mcd_count;
    reg mcd_expired;
    reg int_reset;

    wire reg_hit;
    wire wr_hit;
    assign reg_hit = (reg_addr_in == `PMC_REG_ADDR);
    assign wr_hit = reg_write_in & reg_hit;

    // ************************************************************
    // state decoding
    // ************************************************************
    // the cpu clock is gated in both low power states; one place decides it
    function cpu_halted;
        input [3:0] st;
        begin
            cpu_halted = (st == ST_IDLE) || (st == ST_STOP);
        end
    endfunction

    // oscillators and peripheral clocks stop only in stop mode
    function osc_halted;
        input [3:0] st;
        begin
            osc_halted = (st == ST_STOP);
        end
    endfunction

    // readback image: mode select bits are action strobes, never stored
    function [7:0] read_image;
        input baud;
        input [4:0] flags;
        begin
            read_image = {baud, flags, 2'b00};
        end
    endfunction

    // ************************************************************
    // register storage
    // ************************************************************
    // baud bit is software storage; it survives idle untouched
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            baud_doubler <= 1'b0;
        end else if (wr_hit) begin
            baud_doubler <= reg_wdata_in[`PMC_BIT_BAUD];
        end
    end

    // general flags have no hardware effect at all; plain storage
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            general_flags <= 5'h00;
        end else if (wr_hit) begin
            general_flags <= reg_wdata_in[`PMC_FLAGS_MSB:`PMC_FLAGS_LSB];
        end
    end

    // ************************************************************
    // mode sequencing
    // ************************************************************
    // a mode request is latched on the write and acted on at instruction end
    always @* begin
        next_state = state;
        next_stop_pending = stop_pending;
        case (state)
            ST_RUN: begin
                if (wr_hit && reg_wdata_in[`PMC_BIT_STOP]) begin
                    next_state = ST_IDLE_PEND;
                    next_stop_pending = 1'b1;
                end else if (wr_hit && reg_wdata_in[`PMC_BIT_IDLE]) begin
                    next_state = ST_IDLE_PEND;
                    next_stop_pending = 1'b0;
                end
            end
            ST_IDLE_PEND: begin
                // wait for the setting instruction to finish
                if (instr_done_in) begin
                    next_state = stop_pending ? ST_STOP : ST_IDLE;
                    next_stop_pending = 1'b0;
                end
            end
            ST_IDLE: begin
                if (irq_enabled_in) begin
                    next_state = ST_RUN;
                end
            end
            ST_STOP: begin
                next_state = ST_STOP;
            end
            default: begin
                next_state = ST_RUN;
                next_stop_pending = 1'b0;
            end
        endcase
    end

    // any reset, pin or internal, returns to run; only the pin reset uses the async clear.
    // the internal path is synchronous: mode outputs follow next_state and
    // so drop one cycle after internal_reset_out rises, letting the core see
    // the reset request before its clocks come back
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state <= ST_RUN;
            stop_pending <= 1'b0;
        end else if (int_reset) begin
            state <= ST_RUN;
            stop_pending <= 1'b0;
        end else begin
            state <= next_state;
            stop_pending <= next_stop_pending;
        end
    end

    // ************************************************************
    // missing clock detector and internal reset
    // ************************************************************
    // counting is held off while its own reset pulse is out; otherwise the
    // still-set expiry would raise a second reset once the core is in run
    wire mcd_counting;
    assign mcd_counting = (state == ST_STOP) && mcd_enable_in && !mcd_clock_seen_in
        && !int_reset;

    // counts only while stopped; the model assumes this counter keeps a clock
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mcd_count <= 32'h00000000;
            mcd_expired <= 1'b0;
        end else if (mcd_counting) begin
            if (mcd_count >= MCD_CYCLES - 1) begin
                mcd_expired <= 1'b1;
            end else begin
                mcd_count <= mcd_count + 32'h00000001;
            end
        end else begin
            mcd_count <= 32'h00000000;
            mcd_expired <= 1'b0;
        end
    end

    // one-cycle internal reset pulse from watchdog or detector
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            int_reset <= 1'b0;
        end else begin
            int_reset <= ~int_reset & (watchdog_timeout_in | mcd_expired);
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // read data stands one cycle after the read strobe and is zero otherwise
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_read_in && reg_hit) begin
            reg_rdata_out <= read_image(baud_doubler, general_flags);
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    // outputs follow next_state so they change on the edge the state does, one edge later on an internal reset
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cpu_clk_en_out <= 1'b1;
        end else begin
            cpu_clk_en_out <= !cpu_halted(next_state);
        end
    end

    // peripheral clock stays on in idle so interrupts can wake the cpu
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            periph_clk_en_out <= 1'b1;
        end else begin
            periph_clk_en_out <= !osc_halted(next_state);
        end
    end

    // oscillator off in stop; only a reset brings it back
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            osc_en_out <= 1'b1;
        end else begin
            osc_en_out <= !osc_halted(next_state);
        end
    end

    // idle level for the clock tree and the core
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            idle_out <= 1'b0;
        end else begin
            idle_out <= (next_state == ST_IDLE);
        end
    end

    // stop level; held until a reset pulls the state back to run
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            stop_out <= 1'b0;
        end else begin
            stop_out <= osc_halted(next_state);
        end
    end

    // baud doubler goes straight to the serial port rate selector
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            baud_doubler_out <= 1'b0;
        end else begin
            baud_doubler_out <= baud_doubler;
        end
    end

    // general flags exported for observation only; no hardware acts on them
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            general_flags_out <= 5'h00;
        end else begin
            general_flags_out <= general_flags;
        end
    end

    // internal reset request towards the reset logic; watchdog and detector in the same cycle share one pulse
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            internal_reset_out <= 1'b0;
        end else begin
            internal_reset_out <= int_reset;
        end
    end

    // restart address after any reset is always the bottom of code space
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reset_vector_out <= `PMC_RESET_VECTOR;
        end else begin
            reset_vector_out <= `PMC_RESET_VECTOR;
        end
    end

endmodule // pmc_power_mode

// [pmc_core_model.sv]
// core-side model that retires register-writing instructions
`timescale 1ns/1ps
module pmc_core_model (
    input wire clk_in,
    input wire resetn_in,
    input wire write_seen_in,
    output wire instr_done_out
);
    reg [1:0] pipe;
    // write retires two edges on, so a multi-byte follower always sits in between
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in)
            pipe <= 2'h0;
        else
            pipe <= {pipe[0], write_seen_in};
    end
    assign instr_done_out = pipe[1];
endmodule // pmc_core_model

// [pmc_power_mode_chk.sv]
// concurrent checks on the power mode control ports
`timescale 1ns/1ps
module pmc_power_mode_chk (
    input wire clk_in,
    input wire resetn_in,
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_write_in,
    input wire instr_done_in,
    input wire irq_enabled_in,
    input wire watchdog_timeout_in,
    input wire [7:0] reg_rdata_out,
    input wire cpu_clk_en_out,
    input wire periph_clk_en_out,
    input wire osc_en_out,
    input wire idle_out,
    input wire stop_out,
    input wire baud_doubler_out,
    input wire internal_reset_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    a_mode_read_zero: assert property (reg_rdata_out[1:0] == 2'h0)
        else $error("mode bits read back set");
    a_idle_entry_cause: assert property ($rose(idle_out) |-> $past(instr_done_in))
        else $error("idle entered without completion");
    a_idle_clocks_kept: assert property (idle_out |-> !cpu_clk_en_out && periph_clk_en_out)
        else $error("idle clock gating wrong");
    a_idle_irq_wake: assert property (idle_out && irq_enabled_in |=> !idle_out && cpu_clk_en_out)
        else $error("interrupt did not end idle");
    a_stop_halts_all: assert property (stop_out |-> !osc_en_out && !cpu_clk_en_out
        && !periph_clk_en_out && !idle_out)
        else $error("stop clock gating wrong");
    a_stop_only_reset: assert property (stop_out && !internal_reset_out |=> stop_out)
        else $error("stop left without reset");
    a_watchdog_ends_mode: assert property ((idle_out || stop_out) && watchdog_timeout_in
        |-> ##2 internal_reset_out ##1 !idle_out && !stop_out)
        else $error("watchdog did not end low power");
    a_baud_write: assert property (reg_write_in && reg_addr_in == 8'h87
        |-> ##2 baud_doubler_out == $past(reg_wdata_in[7], 2))
        else $error("baud bit not stored");
endmodule // pmc_power_mode_chk
bind pmc_power_mode pmc_power_mode_chk u_chk (.clk_in, .resetn_in, .reg_addr_in, .reg_wdata_in,
    .reg_write_in, .instr_done_in, .irq_enabled_in, .watchdog_timeout_in, .reg_rdata_out,
    .cpu_clk_en_out, .periph_clk_en_out, .osc_en_out, .idle_out, .stop_out, .baud_doubler_out,
    .internal_reset_out);

// [pmc_power_mode_tb.sv]
// self-checking bench for the power mode control block
`timescale 1ns/1ps
module pmc_power_mode_tb;
    reg clk_in = 1'b0;
    reg resetn_in = 1'b0;
    reg reg_write_in = 1'b0, reg_read_in = 1'b0, irq_enabled_in = 1'b0;
    reg watchdog_timeout_in = 1'b0, mcd_enable_in = 1'b0, mcd_clock_seen_in = 1'b1;
    reg [7:0] reg_addr_in = 8'h87, reg_wdata_in = 8'h00;
    wire instr_done_in, cpu_clk_en_out, periph_clk_en_out, osc_en_out, idle_out, stop_out;
    wire baud_doubler_out, internal_reset_out;
    wire [7:0] reg_rdata_out;
    wire [4:0] general_flags_out;
    wire [15:0] reset_vector_out;
    integer miscompares = 0, total_checks = 0;
    integer reset_pulses = 0;
    always #20 clk_in = ~clk_in;
    // internal reset pulses, counted away from the edge that launches them
    always @(negedge clk_in) if (internal_reset_out === 1'b1) reset_pulses <= reset_pulses + 1;
    // short detector count keeps the stop timeout scenario brief
    pmc_power_mode #(.MCD_CYCLES(10)) u_dut (.clk_in, .resetn_in, .reg_addr_in, .reg_wdata_in,
        .reg_write_in, .reg_read_in, .instr_done_in, .irq_enabled_in, .watchdog_timeout_in,
        .mcd_enable_in, .mcd_clock_seen_in, .reg_rdata_out, .cpu_clk_en_out, .periph_clk_en_out,
        .osc_en_out, .idle_out, .stop_out, .baud_doubler_out, .general_flags_out,
        .internal_reset_out, .reset_vector_out);
    pmc_core_model u_core (.clk_in, .resetn_in,
        .write_seen_in(reg_write_in && reg_addr_in == 8'h87), .instr_done_out(instr_done_in));
    task check(input string name, input [31:0] seen, input [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge clk_in);
    endtask
    // write strobe for one edge, then room for the instruction to retire
    task wr(input [7:0] a, input [7:0] d);
        {reg_addr_in, reg_wdata_in, reg_write_in} = {a, d, 1'b1};
        cyc(1);
        {reg_addr_in, reg_write_in} = {8'h87, 1'b0};
        cyc(4);
    endtask
    task rd(input [7:0] exp);
        reg_read_in = 1'b1;
        cyc(1);
        reg_read_in = 1'b0;
        check("rdata", reg_rdata_out, exp);
    endtask
    task pulse_wdt;
        watchdog_timeout_in = 1'b1;
        cyc(1);
        watchdog_timeout_in = 1'b0;
        cyc(4);
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // watchdog sized far above the roughly 100 cycles of the sequence
    initial begin
        #40000;
        miscompares = miscompares + 1;
        complete_run;
    end
    // reset image, baud and flag storage, foreign address ignored
    task test_registers;
        rd(8'h00);
        wr(8'h87, 8'hA8);
        rd(8'hA8);
        check("baud", baud_doubler_out, 1);
        wr(8'h86, 8'h57);
        rd(8'hA8);
        wr(8'h87, 8'h54);
        rd(8'h54);
        check("flags", general_flags_out, 5'h15);
    endtask
    // idle entry after the write retires, then interrupt wake
    task test_idle_irq;
        wr(8'h87, 8'h01);
        check("idle", {idle_out, cpu_clk_en_out, periph_clk_en_out, osc_en_out}, 4'hB);
        irq_enabled_in = 1'b1;
        cyc(2);
        irq_enabled_in = 1'b0;
        check("idle wake", {idle_out, cpu_clk_en_out}, 2'h1);
    endtask
    // watchdog timeout ends idle and restarts from address zero
    task test_idle_wdt;
        wr(8'h87, 8'h01);
        pulse_wdt;
        check("idle wdt", {idle_out, cpu_clk_en_out, reset_vector_out}, 18'h10000);
    endtask
    // both bits give stop; interrupts ignored, watchdog reset ends it
    task test_stop_wdt;
        wr(8'h87, 8'h03);
        check("stop", {stop_out, idle_out, osc_en_out, cpu_clk_en_out, periph_clk_en_out},
            5'h10);
        irq_enabled_in = 1'b1;
        cyc(4);
        irq_enabled_in = 1'b0;
        check("stop irq", stop_out, 1);
        pulse_wdt;
        check("stop wdt", stop_out, 0);
    endtask
    // detector quiet while the clock is seen, then one reset on timeout
    task test_stop_mcd;
        integer pulses_before;
        wr(8'h87, 8'h02);
        pulses_before = reset_pulses;
        {mcd_enable_in, mcd_clock_seen_in} = 2'h3;
        cyc(20);
        check("mcd clock seen", stop_out, 1);
        {mcd_enable_in, mcd_clock_seen_in} = 2'h2;
        cyc(5);
        check("mcd early", stop_out, 1);
        cyc(12);
        check("mcd fire", {stop_out, osc_en_out, reset_vector_out}, 18'h10000);
        check("mcd reset pulses", reset_pulses - pulses_before, 1);
        {mcd_enable_in, mcd_clock_seen_in} = 2'h1;
    endtask
    initial begin
        cyc(6);
        resetn_in = 1'b1;
        test_registers;
        test_idle_irq;
        test_idle_wdt;
        test_stop_wdt;
        test_stop_mcd;
        complete_run;
    end
endmodule // pmc_power_mode_tb
